// ===== common/acsp_pkg.sv
// Summary of operation
// - Plain mode: select index picks input, ground-referenced
// - Common mode: codes 0-6 against input 8
// - Pair mode ignores common bit; even positive
// - Pair codes 4/5 route half/full reference
// - Acquire after conversion until start pin falls or soft-start delay ends
// - Cap reference: ground, or negative input
// - Address bit resets to zero
// - Ten-bit control word, fixed field order
// - Common bit honoured only outside pair mode
// - Drop words whose address bit mismatches
package acsp_pkg;

  localparam int unsigned MCLK_PERIOD_PS = 4000;

  // Register indices on the plain port
  localparam int unsigned ADDR_W      = 2;
  localparam int unsigned DATA_W      = 16;
  localparam logic [1:0]  CTRL_ADDR   = 2'h0;
  localparam logic [1:0]  STATUS_ADDR = 2'h1;

  // Control word layout
  localparam int unsigned CTRL_W        = 10;
  localparam int unsigned CW_ADDR_BIT   = 9;
  localparam int unsigned CW_PD_HI      = 8;
  localparam int unsigned CW_PD_LO      = 7;
  localparam int unsigned CW_COMMON_REF = 6;
  localparam int unsigned CW_PAIR_MODE  = 5;
  localparam int unsigned CW_CHAN_HI    = 4;
  localparam int unsigned CW_CHAN_LO    = 2;
  localparam int unsigned CW_CONV_START = 1;
  localparam int unsigned CW_EXT_REF    = 0;
  localparam logic [9:0]  CTRL_RESET    = 10'h000;

  // Status word layout
  localparam int unsigned ST_CONVERTING = 0;
  localparam int unsigned ST_ACQ_SHORT  = 1;
  localparam int unsigned ST_POS_LO     = 2;
  localparam int unsigned ST_NEG_LO     = 5;
  localparam int unsigned ST_NEG_GND    = 8;
  localparam int unsigned ST_TEST_LO    = 9;

  // Timing
  localparam int unsigned ACQ_MIN_NS    = 100;
  localparam int unsigned SOFT_START_NS = 400;
  localparam logic [7:0]  ACQ_MIN_CYC   =
    8'((ACQ_MIN_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS);
  localparam logic [7:0]  SOFT_START_CYC =
    8'((SOFT_START_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS);

  // Pair-mode special codes and common-mode negative index
  localparam logic [2:0]  PAIR_PAIRS_MAX = 3'h3;
  localparam logic [2:0]  PAIR_TEST_HALF = 3'h4;
  localparam logic [2:0]  PAIR_TEST_FULL = 3'h5;
  localparam logic [2:0]  COMMON_NEG_IDX = 3'h7;

  typedef enum logic [1:0] {
    ACSP_TEST_NONE = 2'h0,
    ACSP_TEST_HALF = 2'h1,
    ACSP_TEST_FULL = 2'h2
  } acsp_test_t;

  // Gray along the pin-driven acquire <-> convert loop
  typedef enum logic [1:0] {
    ACSP_ACQ  = 2'h0,
    ACSP_CONV = 2'h1,
    ACSP_WAIT = 2'h2
  } acsp_phase_t;

endpackage

// ===== tb/acsp_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
  num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module acsp_bench;
  import acsp_pkg::*;
  logic        mclk, rst, wr, rd, paddr, go, fast, start_n, done;
  logic        smp, conv, cap, ngnd, ext;
  logic [1:0]  addr, pd;
  logic [2:0]  pos, neg;
  logic [15:0] wdata, rdata, r;
  acsp_test_t  tsel;
  int          num_errors = 0;
  int          check_count = 0;
  acsp_top dut_u (.MCLK(mclk), .SYS_RST(rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .PACKAGE_ADDR(paddr), .CONV_START_N(start_n), .CONV_DONE(done),
    .SAMPLE_EN(smp), .CONVERTING(conv), .CAP_TO_NEG(cap), .POS_SEL(pos),
    .NEG_SEL(neg), .NEG_GND(ngnd), .TEST_SEL(tsel), .PD_MODE(pd),
    .EXT_REF_EN(ext));
  acsp_host host_u (.mclk(mclk), .go(go), .fast(fast), .conv(conv),
    .start_n(start_n), .done(done));
  function automatic logic [15:0] cw(logic a, c, p, logic [2:0] k);
    return {6'h0, a, 2'h3, c, p, k, 2'h0};
  endfunction
  task automatic wreg(logic [1:0] a, logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(logic [1:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask
  // One conversion through the host model; early start when f is set
  task automatic run(logic f, logic ecap);
    int i;
    @(posedge mclk);
    fast <= f;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (i = 0; i < 60 && conv !== 1'b1; i++) @(negedge mclk);
    `CHK("run", 1'b1, conv)
    `CHK("cap", ecap, cap)
    for (i = 0; i < 60 && smp !== 1'b1; i++) @(negedge mclk);
    `CHK("conv", 1'b0, conv)
  endtask
  task automatic t_sel();
    logic [3:0] k;
    for (k = 0; k < 8; k++) begin
      wreg(CTRL_ADDR, cw(0, 0, 0, k[2:0]));
      `CHK("pos", k[2:0], pos)
      `CHK("gnd", 1'b1, ngnd)
      `CHK("pd", 2'h3, pd)
    end
    for (k = 0; k < 7; k++) begin
      wreg(CTRL_ADDR, cw(0, 1, 0, k[2:0]));
      `CHK("neg", {k[2:0], 3'h7, 1'b0}, {pos, neg, ngnd})
    end
    // Common bit set too, so pair mode must override it
    for (k = 0; k < 4; k++) begin
      wreg(CTRL_ADDR, cw(0, 1, 1, k[2:0]));
      `CHK("pair", {k[1:0], 1'b0, k[1:0], 1'b1}, {pos, neg})
    end
    wreg(CTRL_ADDR, cw(0, 0, 1, 3'h4));
    `CHK("half", ACSP_TEST_HALF, tsel)
    wreg(CTRL_ADDR, cw(0, 0, 1, 3'h5));
    `CHK("full", ACSP_TEST_FULL, tsel)
    wreg(CTRL_ADDR, cw(0, 0, 1, 3'h6));
    `CHK("rsvd", ACSP_TEST_FULL, tsel)
  endtask
  task automatic t_addr();
    wreg(CTRL_ADDR, cw(0, 0, 0, 3'h1));
    @(posedge mclk) paddr <= 1'b1;
    wreg(CTRL_ADDR, cw(0, 0, 0, 3'h5));
    `CHK("drop", 3'h1, pos)
    wreg(CTRL_ADDR, cw(1, 0, 0, 3'h5));
    `CHK("take", 3'h5, pos)
    @(posedge mclk) paddr <= 1'b0;
  endtask
  task automatic t_conv();
    wreg(CTRL_ADDR, cw(0, 0, 1, 3'h0));
    run(0, 1'b1);
    wreg(CTRL_ADDR, cw(0, 0, 0, 3'h2));
    run(0, 1'b0);
    rreg(STATUS_ADDR);
    `CHK("ok_acq", 1'b0, r[1])
    run(1, 1'b0);
    rreg(STATUS_ADDR);
    `CHK("short", 1'b1, r[1])
    wreg(STATUS_ADDR, 16'h0002);
    rreg(STATUS_ADDR);
    `CHK("clear", 1'b0, r[1])
  endtask
  // Start bit in the word: conversion follows the write edge by the delay
  task automatic t_soft();
    int i;
    wreg(CTRL_ADDR, 16'h0103);
    `CHK("pd2", 2'h2, pd)
    `CHK("ext", 1'b1, ext)
    repeat (SOFT_START_CYC) @(negedge mclk);
    `CHK("wait_acq", 1'b1, smp)
    `CHK("wait_conv", 1'b0, conv)
    @(negedge mclk);
    `CHK("soft", 1'b1, conv)
    for (i = 0; i < 60 && smp !== 1'b1; i++) @(negedge mclk);
    `CHK("soft_end", 1'b1, smp)
    rreg(CTRL_ADDR);
    `CHK("ctrl_end", 16'h0101, r)
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Bound well above the few hundred cycles the tests take
  initial begin
    #40000;
    num_errors++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {wr, rd, go, fast, addr, wdata} = '0;
    paddr = 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rreg(CTRL_ADDR);
    `CHK("ctrl", 16'h0000, r)
    `CHK("acq", 1'b1, smp)
    t_sel();
    t_addr();
    t_conv();
    t_soft();
    conclude();
  end
endmodule

// ===== tb/acsp_chk.sv
`timescale 1ns/100ps
module acsp_chk
  import acsp_pkg::*;
(
  input wire logic        MCLK,         // Clock
  input wire logic        SYS_RST,      // Reset
  input wire logic [1:0]  REG_ADDR,     // Index
  input wire logic [15:0] REG_WDATA,    // Write data
  input wire logic        REG_WR,       // Write strobe
  input wire logic        PACKAGE_ADDR, // Strap
  input wire logic        CONV_START_N, // Start pin
  input wire logic        CONV_DONE,    // Done
  input wire logic        SAMPLE_EN,    // Acquire
  input wire logic        CONVERTING,   // Convert
  input wire logic        CAP_TO_NEG,   // Cap side
  input wire logic [2:0]  POS_SEL,      // Positive
  input wire logic [2:0]  NEG_SEL,      // Negative
  input wire logic        NEG_GND,      // Ground
  input wire acsp_test_t  TEST_SEL,     // Test source
  input wire logic [1:0]  PD_MODE,      // Power-down
  input wire logic        EXT_REF_EN    // Ext ref
);
  logic       ok;
  logic [2:0] k;
  logic [9:0] w_q;
  assign ok = REG_WR && REG_ADDR == CTRL_ADDR && REG_WDATA[9] == PACKAGE_ADDR;
  assign k = REG_WDATA[4:2];
  always_ff @(posedge MCLK) w_q <= REG_WDATA[9:0];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  a_start_edge: assert property ($fell(CONV_START_N) && SAMPLE_EN
    |=> CONVERTING && !SAMPLE_EN) else $error("start edge missed");
  a_done_back: assert property (CONVERTING && CONV_DONE
    |=> SAMPLE_EN && !CONVERTING) else $error("no return to acquire");
  a_cap_side: assert property ($rose(CONVERTING)
    |-> CAP_TO_NEG == !NEG_GND) else $error("cap side wrong");
  a_plain_sel: assert property (ok && !REG_WDATA[5] && !REG_WDATA[6]
    |=> POS_SEL == w_q[4:2] && NEG_GND) else $error("plain select");
  a_common_sel: assert property (
    ok && REG_WDATA[6:5] == 2'h2 && k != 3'h7
    |=> POS_SEL == w_q[4:2] && NEG_SEL == 3'h7 && !NEG_GND)
    else $error("common select");
  a_pair_sel: assert property (ok && REG_WDATA[5] && !k[2]
    |=> POS_SEL == {w_q[3:2], 1'b0} && NEG_SEL == {w_q[3:2], 1'b1})
    else $error("pair select");
  a_test_src: assert property (ok && REG_WDATA[5] && k[2:1] == 2'h2
    |=> TEST_SEL == (w_q[2] ? ACSP_TEST_FULL : ACSP_TEST_HALF))
    else $error("test source");
  a_reserved_keep: assert property (
    ok && REG_WDATA[5] && k[2:1] == 2'h3
    |=> $stable(POS_SEL) && $stable(TEST_SEL))
    else $error("reserved code moved");
  a_addr_drop: assert property (REG_WR && REG_ADDR == CTRL_ADDR
    && REG_WDATA[9] != PACKAGE_ADDR |=> $stable(POS_SEL) && $stable(PD_MODE))
    else $error("foreign word taken");
  a_word_fields: assert property (ok
    |=> PD_MODE == w_q[8:7] && EXT_REF_EN == w_q[0]) else $error("fields");
  cover property ($rose(CONVERTING));
  cover property (ok && REG_WDATA[5]);
  cover property (REG_WR && REG_WDATA[9] != PACKAGE_ADDR);
endmodule
bind acsp_top acsp_chk chk_u (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .PACKAGE_ADDR(PACKAGE_ADDR), .CONV_START_N(CONV_START_N),
  .CONV_DONE(CONV_DONE), .SAMPLE_EN(SAMPLE_EN), .CONVERTING(CONVERTING),
  .CAP_TO_NEG(CAP_TO_NEG), .POS_SEL(POS_SEL), .NEG_SEL(NEG_SEL),
  .NEG_GND(NEG_GND), .TEST_SEL(TEST_SEL), .PD_MODE(PD_MODE),
  .EXT_REF_EN(EXT_REF_EN));

// ===== tb/acsp_host.sv
`timescale 1ns/100ps
module acsp_host #(
  parameter int CONV_CYC = 12 // Modelled conversion length
) (
  input  wire logic mclk,    // Clock
  input  wire logic go,      // Request one conversion
  input  wire logic fast,    // Start too early on purpose
  input  wire logic conv,    // Device converting
  output      logic start_n, // Conversion start pin
  output      logic done     // Converter finished
);
  int   n       = 0;
  int   c       = 0;
  logic start_q = 1'b1;
  logic done_q  = 1'b0;
  // One driver per pin: the pins follow the model's own flops
  assign start_n = start_q;
  assign done    = done_q;
  always @(posedge mclk) begin
    if (go)
      n <= fast ? 4 : 27;
    else if (n > 0)
      n <= n - 1;
    start_q <= !(n == 1 || n == 2);
    c <= conv ? c + 1 : 0;
    done_q <= conv && c == CONV_CYC;
  end
endmodule

// ===== verilog/acsp_decode.sv
`timescale 1ns/100ps
module acsp_decode (
  input  wire logic                common_ref, // Common-reference bit
  input  wire logic                pair_mode,  // Pair-mode bit
  input  wire logic [2:0]          chan_sel,   // Channel select code
  output      logic                sel_valid,  // Code defines a selection
  output      logic [2:0]          pos_idx,    // Positive input index
  output      logic [2:0]          neg_idx,    // Negative input index
  output      logic                neg_gnd,    // Negative side is ground
  output      acsp_pkg::acsp_test_t test_sel  // Internal test source
);
  import acsp_pkg::*;

  always_comb begin
    sel_valid = 1'b1;
    pos_idx   = chan_sel;
    neg_idx   = 3'h0;
    neg_gnd   = 1'b1;
    test_sel  = ACSP_TEST_NONE;
    if (pair_mode) begin
      neg_gnd = 1'b0;
      if (chan_sel <= PAIR_PAIRS_MAX) begin
        pos_idx = {chan_sel[1:0], 1'b0};
        neg_idx = {chan_sel[1:0], 1'b1};
      end else if (chan_sel == PAIR_TEST_HALF) begin
        test_sel = ACSP_TEST_HALF;
      end else if (chan_sel == PAIR_TEST_FULL) begin
        test_sel = ACSP_TEST_FULL;
      end else begin
        sel_valid = 1'b0;
      end
    end else if (common_ref) begin
      neg_gnd = 1'b0;
      neg_idx = COMMON_NEG_IDX;
      // Code 7 would measure input 8 against itself
      sel_valid = (chan_sel != COMMON_NEG_IDX);
    end else begin
      neg_gnd = 1'b1;
    end
  end

endmodule

// ===== verilog/acsp_top.sv
`timescale 1ns/100ps
module acsp_top
  import acsp_pkg::*;
(
  input  wire logic                  MCLK,         // 250 MHz clock
  input  wire logic                  SYS_RST,      // Async reset, high
  input  wire logic [1:0]            REG_ADDR,     // Register index
  input  wire logic [15:0]           REG_WDATA,    // Write data
  input  wire logic                  REG_WR,       // Write strobe
  input  wire logic                  REG_RD,       // Read strobe
  output      logic [15:0]           REG_RDATA,    // Read data, next cycle
  input  wire logic                  PACKAGE_ADDR, // Address strap pin
  input  wire logic                  CONV_START_N, // Conversion start
  input  wire logic                  CONV_DONE,    // Converter finished
  output      logic                  SAMPLE_EN,    // Acquisition phase
  output      logic                  CONVERTING,   // Conversion phase
  output      logic                  CAP_TO_NEG,   // Cap ref on neg input
  output      logic [2:0]            POS_SEL,      // Positive input index
  output      logic [2:0]            NEG_SEL,      // Negative input index
  output      logic                  NEG_GND,      // Negative side ground
  output      acsp_pkg::acsp_test_t  TEST_SEL,     // Internal test source
  output      logic [1:0]            PD_MODE,      // Power-down bits
  output      logic                  EXT_REF_EN    // External reference
);
  import acsp_pkg::*;

  typedef struct packed {
    logic [9:0]  ctrl;
    acsp_phase_t phase;
    logic        start_n_prev;
    logic [7:0]  acq_cnt;
    logic [7:0]  soft_cnt;
    logic        acq_short;
    logic [2:0]  pos;
    logic [2:0]  neg;
    logic        neg_gnd;
    acsp_test_t  test;
    logic        sample_en;
    logic        converting;
    logic        cap_to_neg;
    logic [15:0] rdata;
  } acsp_state_t;

  localparam acsp_state_t STATE_RESET = '{
    ctrl:         CTRL_RESET,
    phase:        ACSP_ACQ,
    start_n_prev: 1'b1,
    acq_cnt:      8'h00,
    soft_cnt:     8'h00,
    acq_short:    1'b0,
    pos:          3'h0,
    neg:          3'h0,
    neg_gnd:      1'b1,
    test:         ACSP_TEST_NONE,
    sample_en:    1'b1,
    converting:   1'b0,
    cap_to_neg:   1'b0,
    rdata:        16'h0000
  };

  acsp_state_t state_q;
  acsp_state_t state_d;

  logic        wr_ctrl;
  logic        addr_ok;
  logic        dec_valid;
  logic [2:0]  dec_pos;
  logic [2:0]  dec_neg;
  logic        dec_gnd;
  acsp_test_t  dec_test;
  logic        start_fall;
  logic        go_conv;
  logic [15:0] status_word;

  assign wr_ctrl = REG_WR && (REG_ADDR == CTRL_ADDR);
  assign addr_ok = (REG_WDATA[CW_ADDR_BIT] == PACKAGE_ADDR);
  assign start_fall = state_q.start_n_prev && !CONV_START_N;

  acsp_decode u_decode (
    .common_ref (REG_WDATA[CW_COMMON_REF]),
    .pair_mode  (REG_WDATA[CW_PAIR_MODE]),
    .chan_sel   (REG_WDATA[CW_CHAN_HI:CW_CHAN_LO]),
    .sel_valid  (dec_valid),
    .pos_idx    (dec_pos),
    .neg_idx    (dec_neg),
    .neg_gnd    (dec_gnd),
    .test_sel   (dec_test)
  );

  always_comb begin
    status_word = 16'h0000;
    status_word[ST_CONVERTING]            = state_q.converting;
    status_word[ST_ACQ_SHORT]             = state_q.acq_short;
    status_word[ST_POS_LO +: 3]           = state_q.pos;
    status_word[ST_NEG_LO +: 3]           = state_q.neg;
    status_word[ST_NEG_GND]               = state_q.neg_gnd;
    status_word[ST_TEST_LO +: 2]          = state_q.test;
  end

  always_comb begin
    state_d = state_q;
    go_conv = 1'b0;
    state_d.start_n_prev = CONV_START_N;

    if (wr_ctrl && addr_ok) begin
      state_d.ctrl = REG_WDATA[CTRL_W-1:0];
      // Selection moves only with a defined code
      if (dec_valid) begin
        state_d.pos     = dec_pos;
        state_d.neg     = dec_neg;
        state_d.neg_gnd = dec_gnd;
        state_d.test    = dec_test;
      end
    end

    if (state_q.acq_cnt != ACQ_MIN_CYC) begin
      state_d.acq_cnt = state_q.acq_cnt + 8'h01;
    end

    unique case (state_q.phase)
      ACSP_ACQ: begin
        if (start_fall) begin
          go_conv = 1'b1;
        end else if (wr_ctrl && addr_ok && REG_WDATA[CW_CONV_START]) begin
          // Delay lets a new channel settle before the hold
          state_d.phase    = ACSP_WAIT;
          state_d.soft_cnt = 8'h01;
        end
      end
      ACSP_WAIT: begin
        if (start_fall || state_q.soft_cnt == SOFT_START_CYC) begin
          go_conv = 1'b1;
        end else begin
          state_d.soft_cnt = state_q.soft_cnt + 8'h01;
        end
      end
      ACSP_CONV: begin
        if (CONV_DONE) begin
          state_d.phase   = ACSP_ACQ;
          state_d.acq_cnt = 8'h00;
          state_d.ctrl[CW_CONV_START] = 1'b0;
        end
      end
      default: begin
        state_d.phase = ACSP_ACQ;
      end
    endcase

    if (go_conv) begin
      state_d.phase = ACSP_CONV;
      // Flag a hold before settling ends
      if (state_q.acq_cnt != ACQ_MIN_CYC) begin
        state_d.acq_short = 1'b1;
      end
    end else if (REG_WR && REG_ADDR == STATUS_ADDR
                 && REG_WDATA[ST_ACQ_SHORT]) begin
      // Clear loses to a same-cycle event
      state_d.acq_short = 1'b0;
    end

    state_d.sample_en  = (state_d.phase != ACSP_CONV);
    state_d.converting = (state_d.phase == ACSP_CONV);
    state_d.cap_to_neg = state_d.converting && !state_d.neg_gnd;

    state_d.rdata = 16'h0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        CTRL_ADDR:   state_d.rdata = {6'h00, state_q.ctrl};
        STATUS_ADDR: state_d.rdata = status_word;
        default:     state_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign REG_RDATA  = state_q.rdata;
  assign SAMPLE_EN  = state_q.sample_en;
  assign CONVERTING = state_q.converting;
  assign CAP_TO_NEG = state_q.cap_to_neg;
  assign POS_SEL    = state_q.pos;
  assign NEG_SEL    = state_q.neg;
  assign NEG_GND    = state_q.neg_gnd;
  assign TEST_SEL   = state_q.test;
  assign PD_MODE    = state_q.ctrl[CW_PD_HI:CW_PD_LO];
  assign EXT_REF_EN = state_q.ctrl[CW_EXT_REF];

endmodule
